// *** iss_pkg.sv ***
package iss_pkg;
	localparam int CLK_MHZ = 125;
	localparam int HRST_WAIT_NS = 10000;
	localparam int HRST_WAIT_CYC = (HRST_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int HRST_W = 11;
	localparam int ROW_W = 13;
	localparam int IDX_W = 9;
	localparam int IDX_LSB = 2;
	localparam int TIME_W = 16;
	localparam int MODE_W = 4;
	localparam int LVDS_W = 3;
	localparam int FRM_W = 16;
	localparam int DEF_ROWS = 5120;
	localparam int DEF_FOT_CYC = 64;
	localparam int DEF_LINE_CYC = 16;
	localparam logic [IDX_W-1:0] IDX_STATUS = 9'h008;
	localparam logic [IDX_W-1:0] IDX_PTR = 9'h009;
	localparam logic [IDX_W-1:0] IDX_LOGIC = 9'h022;
	localparam logic [IDX_W-1:0] LOW_LIMIT = 9'h028;
	localparam logic [IDX_W-1:0] IDX_LVDS = 9'h070;
	localparam logic [IDX_W-1:0] IDX_MODE = 9'h0c0;
	localparam logic [IDX_W-1:0] IDX_INT = 9'h0c9;
	localparam logic [IDX_W-1:0] IDX_SEQ_CFG = 9'h1c0;
	localparam int LOGIC_EN = 0;
	localparam int MODE_SEQ_EN = 0;
	localparam int MODE_ROLL = 1;
	localparam int MODE_SLAVE = 2;
	localparam int MODE_TRIG = 3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int HTRANS_ACT = 1;
	typedef enum logic [2:0] {
		OP_OFF = 3'b000,
		OP_STBY1 = 3'b001,
		OP_INTER = 3'b010,
		OP_STBY2 = 3'b011,
		OP_IDLE = 3'b100,
		OP_RUN = 3'b101
	} iss_op_e;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_FOT = 2'b01,
		RD_ROWS = 2'b10
	} iss_rd_e;
endpackage : iss_pkg

// *** iss_roll_ptr.sv ***
`timescale 1ns/1ps
module iss_roll_ptr import iss_pkg::*; #(
	parameter int ROWS = DEF_ROWS
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic en_i,
	input wire logic row_tick_i,
	input wire logic [TIME_W-1:0] exp_rows_i,
	output logic [ROW_W-1:0] read_row_o,
	output logic [ROW_W-1:0] reset_row_o,
	output logic read_valid_o,
	output logic frame_start_o
);
	localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(ROWS - 1);
	localparam logic [ROW_W:0] ROWS_X = (ROW_W + 1)'(ROWS);

	generate
		if (ROWS < 2 || ROWS >= (1 << ROW_W)) begin : g_bad_param
			$error("iss_roll_ptr: parameter out of range");
		end
	endgenerate

	typedef struct packed {
		logic valid;
		logic fstart;
		logic [ROW_W-1:0] rd;
		logic [ROW_W-1:0] rst;
		logic [ROW_W-1:0] warm;
		logic [ROW_W-1:0] expo;
	} iss_roll_s;

	iss_roll_s st_ff;
	iss_roll_s nxt_st;

	function automatic logic [ROW_W-1:0] row_inc(input logic [ROW_W-1:0] a);
		row_inc = (a == LAST_ROW) ? '0 : ROW_W'(a + 1'b1);
	endfunction : row_inc

	function automatic logic [ROW_W-1:0] row_add(input logic [ROW_W-1:0] a, input logic [ROW_W-1:0] b);
		logic [ROW_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= ROWS_X) begin
			s = s - ROWS_X;
		end
		row_add = s[ROW_W-1:0];
	endfunction : row_add

	function automatic logic [ROW_W-1:0] clamp_exp(input logic [TIME_W-1:0] e);
		if (e == '0) begin
			clamp_exp = ROW_W'(1);
		end else if (e > TIME_W'(ROWS - 1)) begin
			clamp_exp = LAST_ROW;
		end else begin
			clamp_exp = e[ROW_W-1:0];
		end
	endfunction : clamp_exp

	always_comb begin
		nxt_st = st_ff;
		nxt_st.fstart = 1'b0;
		if (!en_i) begin
			nxt_st.valid = 1'b0;
			nxt_st.rd = '0;
			nxt_st.rst = '0;
			nxt_st.warm = '0;
			nxt_st.expo = clamp_exp(exp_rows_i);
		end else if (row_tick_i) begin
			if (!st_ff.valid) begin
				// reset pointer runs ahead alone until the distance is built up
				nxt_st.rst = row_inc(st_ff.rst);
				nxt_st.warm = ROW_W'(st_ff.warm + 1'b1);
				if (st_ff.warm == ROW_W'(st_ff.expo - 1'b1)) begin
					nxt_st.valid = 1'b1;
					nxt_st.rd = '0;
					nxt_st.fstart = 1'b1;
				end
			end else begin
				nxt_st.rd = row_inc(st_ff.rd);
				// new exposure taken at the read wrap so the read stream never stalls
				if (st_ff.rd == LAST_ROW) begin
					nxt_st.expo = clamp_exp(exp_rows_i);
					nxt_st.fstart = 1'b1;
				end
				nxt_st.rst = row_add(nxt_st.rd, nxt_st.expo);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign read_row_o = st_ff.rd;
	assign reset_row_o = st_ff.rst;
	assign read_valid_o = st_ff.valid;
	assign frame_start_o = st_ff.fstart;

	a_ptr_distance: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		en_i && st_ff.valid |-> st_ff.rst == row_add(st_ff.rd, st_ff.expo))
		else $error("reset pointer not at exposure distance from read pointer");
	a_read_steps: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		en_i && st_ff.valid && row_tick_i |=> st_ff.rd == row_inc($past(st_ff.rd)))
		else $error("read pointer did not step by one row");
	c_roll_frame: cover property (@(posedge sys_clk_i) disable iff (srst_i) st_ff.fstart && st_ff.rd == '0);
endmodule : iss_roll_ptr

// *** iss_seq.sv ***
`timescale 1ns/1ps
// Overview of operation
// - triggered mode: one image, then wait
// - each trigger arriving with no integration or sample pending yields exactly one readout
// - next integration may overlap prior readout
// - master: rising edge starts programmed integration
// - master: integration end starts overhead, rows
// - master: falling edges ignored, rises ignored while integrating
// - slave: pin high integrates, low samples
// - slave: new assertion requests new frame
// - rolling: reset pointer and read pointer
// - exposure equals pointer row distance
// - rows sequential, equal integration per row
// - exposure changes taken without stream break
// - six operating states by power
// - first standby: only low registers writable
// - second standby: all registers accessible
// - intermediate standby until reserved upload
// - idle: sequencer off, enabling starts grabbing
// - running: grab continuously in chosen mode
// - mode writes keep operating state while sequencer enable stays set
// - reset release enters first standby
// - slave ignores integration time register
module iss_seq import iss_pkg::*; #(
	parameter int ROWS = DEF_ROWS,
	parameter int FOT_CYC = DEF_FOT_CYC,
	parameter int LINE_CYC = DEF_LINE_CYC
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic sync_pin_i,
	output logic [2:0] op_state_o,
	output logic integrating_o,
	output logic [1:0] readout_phase_o,
	output logic [ROW_W-1:0] global_row_o,
	output logic frame_done_o,
	output logic [ROW_W-1:0] roll_read_row_o,
	output logic [ROW_W-1:0] roll_reset_row_o,
	output logic roll_read_valid_o,
	output logic roll_frame_start_o
);
	generate
		if (ROWS < 2 || ROWS >= (1 << ROW_W) || FOT_CYC < 1 || FOT_CYC > 65535 ||
			LINE_CYC < 1 || LINE_CYC > 65535) begin : g_bad_param
			$error("iss_seq: parameter out of range");
		end
	endgenerate

	typedef struct packed {
		logic sync_meta;
		logic sync_now;
		logic sync_prev;
		iss_op_e op;
		logic [HRST_W-1:0] hrst_cnt;
		logic hrst_ok;
		logic pend;
		logic pwr;
		logic pmap;
		logic [IDX_W-1:0] pidx;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
		logic logic_en;
		logic [LVDS_W-1:0] lvds;
		logic [MODE_W-1:0] mode;
		logic [TIME_W-1:0] int_time;
		logic [TIME_W-1:0] seq_cfg;
		logic [TIME_W-1:0] div_cnt;
		logic row_tick;
		logic integ;
		logic [TIME_W-1:0] integ_cnt;
		logic pend_sample;
		iss_rd_e rphase;
		logic [TIME_W-1:0] fot_cnt;
		logic [ROW_W-1:0] row_cnt;
		logic frame_done;
		logic [FRM_W-1:0] frames;
	} iss_seq_s;

	iss_seq_s st_ff;
	iss_seq_s nxt_st;
	logic rise;
	logic fall;
	logic accept;
	logic wr_en;
	logic glob_en;
	logic roll_en;
	logic start_req;
	logic [31:0] rd_word;
	logic [ROW_W-1:0] roll_rd;
	logic [ROW_W-1:0] roll_rst;
	logic roll_valid;
	logic roll_fstart;

	function automatic logic wr_allowed(input iss_op_e op, input logic [IDX_W-1:0] idx);
		case (op)
			OP_OFF: wr_allowed = 1'b0;
			OP_STBY1: wr_allowed = (idx < LOW_LIMIT);
			default: wr_allowed = 1'b1;
		endcase
	endfunction : wr_allowed

	function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t);
		clamp_time = (t == '0) ? TIME_W'(1) : t;
	endfunction : clamp_time

	assign roll_en = (st_ff.op == OP_RUN) & st_ff.mode[MODE_ROLL];

	always_comb begin
		nxt_st = st_ff;
		// the first stage feeds only the second; edges come from the later pair
		nxt_st.sync_meta = sync_pin_i;
		nxt_st.sync_now = st_ff.sync_meta;
		nxt_st.sync_prev = st_ff.sync_now;
		rise = st_ff.sync_now & ~st_ff.sync_prev;
		fall = ~st_ff.sync_now & st_ff.sync_prev;
		glob_en = (st_ff.op == OP_RUN) & ~st_ff.mode[MODE_ROLL];
		start_req = 1'b0;
		nxt_st.frame_done = 1'b0;
		nxt_st.hresp = 1'b0;

		// settle-time flag only reports; early writes are still served
		if (!st_ff.hrst_ok) begin
			if (st_ff.hrst_cnt == HRST_W'(HRST_WAIT_CYC - 1)) begin
				nxt_st.hrst_ok = 1'b1;
			end else begin
				nxt_st.hrst_cnt = HRST_W'(st_ff.hrst_cnt + 1'b1);
			end
		end

		case (st_ff.pidx)
			IDX_STATUS: rd_word = {st_ff.frames, 8'h00, roll_valid, st_ff.rphase, st_ff.integ, st_ff.hrst_ok, st_ff.op};
			IDX_PTR: rd_word = {3'h0, roll_rst, 3'h0, roll_rd};
			IDX_LOGIC: rd_word = 32'(st_ff.logic_en);
			IDX_LVDS: rd_word = 32'(st_ff.lvds);
			IDX_MODE: rd_word = 32'(st_ff.mode);
			IDX_INT: rd_word = 32'(st_ff.int_time);
			IDX_SEQ_CFG: rd_word = 32'(st_ff.seq_cfg);
			default: rd_word = 32'h0000_0000;
		endcase
		if (!st_ff.pmap) begin
			rd_word = 32'h0000_0000;
		end

		// one wait state per transfer keeps hrdata straight from a flop
		accept = hsel_i & hready_i & htrans_i[HTRANS_ACT] & st_ff.hready;
		wr_en = st_ff.pend & st_ff.pwr & st_ff.pmap & wr_allowed(st_ff.op, st_ff.pidx);
		if (accept) begin
			nxt_st.pend = 1'b1;
			nxt_st.pwr = hwrite_i & (hsize_i == HSIZE_WORD);
			nxt_st.pmap = (haddr_i[31:IDX_LSB+IDX_W] == '0);
			nxt_st.pidx = haddr_i[IDX_LSB +: IDX_W];
			nxt_st.hready = 1'b0;
		end else if (st_ff.pend) begin
			nxt_st.pend = 1'b0;
			nxt_st.hready = 1'b1;
			nxt_st.hrdata = rd_word;
		end

		if (wr_en) begin
			case (st_ff.pidx)
				IDX_LOGIC: nxt_st.logic_en = hwdata_i[LOGIC_EN];
				IDX_LVDS: nxt_st.lvds = hwdata_i[LVDS_W-1:0];
				IDX_MODE: nxt_st.mode = hwdata_i[MODE_W-1:0];
				IDX_INT: nxt_st.int_time = hwdata_i[TIME_W-1:0];
				IDX_SEQ_CFG: nxt_st.seq_cfg = hwdata_i[TIME_W-1:0];
				default: ;
			endcase
		end

		// apart from leaving OP_OFF, state moves only on what software has written
		case (st_ff.op)
			OP_OFF: nxt_st.op = OP_STBY1;
			OP_STBY1: begin
				if (nxt_st.logic_en) begin
					nxt_st.op = OP_INTER;
				end
			end
			OP_INTER: begin
				if (!nxt_st.logic_en) begin
					nxt_st.op = OP_STBY1;
				end else if (wr_en && st_ff.pidx == IDX_SEQ_CFG) begin
					nxt_st.op = OP_STBY2;
				end
			end
			OP_STBY2: begin
				if (!nxt_st.logic_en) begin
					nxt_st.op = OP_STBY1;
				end else if (nxt_st.lvds != '0) begin
					nxt_st.op = OP_IDLE;
				end
			end
			OP_IDLE: begin
				if (nxt_st.lvds == '0) begin
					nxt_st.op = OP_STBY2;
				end else if (nxt_st.mode[MODE_SEQ_EN]) begin
					nxt_st.op = OP_RUN;
				end
			end
			OP_RUN: begin
				if (!nxt_st.mode[MODE_SEQ_EN]) begin
					nxt_st.op = OP_IDLE;
				end
			end
			default: nxt_st.op = OP_OFF;
		endcase

		if (st_ff.div_cnt == TIME_W'(LINE_CYC - 1)) begin
			nxt_st.div_cnt = '0;
			nxt_st.row_tick = 1'b1;
		end else begin
			nxt_st.div_cnt = TIME_W'(st_ff.div_cnt + 1'b1);
			nxt_st.row_tick = 1'b0;
		end

		if (!glob_en) begin
			nxt_st.integ = 1'b0;
			nxt_st.pend_sample = 1'b0;
			nxt_st.rphase = RD_IDLE;
			nxt_st.row_cnt = '0;
		end else begin
			if (st_ff.mode[MODE_SLAVE]) begin
				// pin level alone times the exposure here
				if (!st_ff.integ && !st_ff.pend_sample && rise) begin
					nxt_st.integ = 1'b1;
				end else if (st_ff.integ && fall) begin
					nxt_st.integ = 1'b0;
					nxt_st.pend_sample = 1'b1;
				end
			end else begin
				start_req = st_ff.mode[MODE_TRIG] ? rise : 1'b1;
				if (!st_ff.integ && !st_ff.pend_sample && start_req) begin
					nxt_st.integ = 1'b1;
					nxt_st.integ_cnt = clamp_time(st_ff.int_time);
				end else if (st_ff.integ && st_ff.row_tick) begin
					if (st_ff.integ_cnt == TIME_W'(1)) begin
						nxt_st.integ = 1'b0;
						nxt_st.pend_sample = 1'b1;
					end else begin
						nxt_st.integ_cnt = TIME_W'(st_ff.integ_cnt - 1'b1);
					end
				end
			end
			// integration may run again while the previous image is read
			case (st_ff.rphase)
				RD_IDLE: begin
					if (st_ff.pend_sample) begin
						nxt_st.pend_sample = 1'b0;
						nxt_st.rphase = RD_FOT;
						nxt_st.fot_cnt = TIME_W'(FOT_CYC - 1);
					end
				end
				RD_FOT: begin
					if (st_ff.fot_cnt == '0) begin
						nxt_st.rphase = RD_ROWS;
						nxt_st.row_cnt = '0;
					end else begin
						nxt_st.fot_cnt = TIME_W'(st_ff.fot_cnt - 1'b1);
					end
				end
				RD_ROWS: begin
					if (st_ff.row_tick) begin
						if (st_ff.row_cnt == ROW_W'(ROWS - 1)) begin
							nxt_st.rphase = RD_IDLE;
							nxt_st.frame_done = 1'b1;
							nxt_st.frames = FRM_W'(st_ff.frames + 1'b1);
						end else begin
							nxt_st.row_cnt = ROW_W'(st_ff.row_cnt + 1'b1);
						end
					end
				end
				default: nxt_st.rphase = RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_ff <= '0;
			st_ff.hready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	iss_roll_ptr #(
		.ROWS(ROWS)
	) u_roll (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.en_i(roll_en),
		.row_tick_i(st_ff.row_tick),
		.exp_rows_i(st_ff.int_time),
		.read_row_o(roll_rd),
		.reset_row_o(roll_rst),
		.read_valid_o(roll_valid),
		.frame_start_o(roll_fstart)
	);

	assign hreadyout_o = st_ff.hready;
	assign hresp_o = st_ff.hresp;
	assign hrdata_o = st_ff.hrdata;
	assign op_state_o = st_ff.op;
	assign integrating_o = st_ff.integ;
	assign readout_phase_o = st_ff.rphase;
	assign global_row_o = st_ff.row_cnt;
	assign frame_done_o = st_ff.frame_done;
	assign roll_read_row_o = roll_rd;
	assign roll_reset_row_o = roll_rst;
	assign roll_read_valid_o = roll_valid;
	assign roll_frame_start_o = roll_fstart;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	a_reset_entry: assert property ($fell(srst_i) |-> st_ff.op == OP_OFF ##1 st_ff.op == OP_STBY1)
		else $error("reset release did not lead to first standby");
	a_high_wr_blocked: assert property (st_ff.op == OP_STBY1 && st_ff.pend && st_ff.pwr &&
		st_ff.pidx == IDX_LVDS |=> $stable(st_ff.lvds))
		else $error("high register written in first standby");
	a_low_wr_stby1: assert property (st_ff.op == OP_STBY1 && st_ff.pend && st_ff.pwr && st_ff.pmap &&
		st_ff.pidx == IDX_LOGIC && hwdata_i[LOGIC_EN] |=> st_ff.logic_en ##1 st_ff.op == OP_INTER)
		else $error("low register write refused in first standby");
	a_stby2_access: assert property (st_ff.op == OP_STBY2 && st_ff.pend && st_ff.pwr && st_ff.pmap &&
		st_ff.pidx == IDX_INT |=> st_ff.int_time == $past(hwdata_i[TIME_W-1:0]))
		else $error("register not writable in second standby");
	a_inter_exit: assert property (st_ff.op == OP_INTER && wr_en && st_ff.pidx == IDX_SEQ_CFG &&
		st_ff.logic_en |=> st_ff.op == OP_STBY2)
		else $error("reserved upload did not reach second standby");
	a_idle_to_run: assert property (st_ff.op == OP_IDLE && st_ff.lvds != '0 && wr_en && st_ff.pidx == IDX_MODE &&
		hwdata_i[MODE_SEQ_EN] |=> st_ff.op == OP_RUN)
		else $error("sequencer enable did not start running");
	a_mode_keeps_state: assert property (st_ff.op == OP_RUN && wr_en && st_ff.pidx == IDX_MODE &&
		hwdata_i[MODE_SEQ_EN] |=> st_ff.op == OP_RUN)
		else $error("mode write moved the operating state");
	a_trig_wait: assert property (glob_en && st_ff.mode[MODE_TRIG] && !st_ff.mode[MODE_SLAVE] &&
		!st_ff.integ && !rise && !st_ff.pend_sample |=> !st_ff.integ)
		else $error("triggered master integrated without a rising edge");
	a_master_start: assert property (glob_en && !st_ff.mode[MODE_SLAVE] && st_ff.mode[MODE_TRIG] &&
		!st_ff.integ && !st_ff.pend_sample && rise |=> st_ff.integ && st_ff.integ_cnt == clamp_time(st_ff.int_time))
		else $error("rising edge did not start programmed integration");
	a_fall_ignored: assert property (glob_en && !st_ff.mode[MODE_SLAVE] && st_ff.integ && fall &&
		!st_ff.row_tick |=> st_ff.integ)
		else $error("falling edge ended master integration");
	a_slave_sample: assert property (glob_en && st_ff.mode[MODE_SLAVE] && st_ff.integ && fall
		|=> !st_ff.integ && (st_ff.pend_sample || st_ff.rphase == RD_FOT))
		else $error("slave deassertion did not request sampling");
	a_fot_start: assert property (glob_en && st_ff.rphase == RD_IDLE && st_ff.pend_sample &&
		$stable(st_ff.op) |=> st_ff.rphase == RD_FOT && st_ff.fot_cnt == TIME_W'(FOT_CYC - 1))
		else $error("overhead interval did not follow integration");
	a_one_frame: assert property (st_ff.frame_done |-> st_ff.frames == FRM_W'($past(st_ff.frames) + 1'b1)
		&& st_ff.rphase == RD_IDLE)
		else $error("frame completion miscounted");
	a_bus_answer: assert property (accept |=> !hreadyout_o ##1 hreadyout_o && !hresp_o)
		else $error("bus transfer not answered in two cycles");

	c_trig_frame: cover property (st_ff.mode[MODE_TRIG] && st_ff.frame_done);
	c_slave_integ: cover property (st_ff.mode[MODE_SLAVE] && st_ff.integ ##1 !st_ff.integ);
	c_overlap: cover property (st_ff.integ && st_ff.rphase == RD_ROWS);
	c_running: cover property (st_ff.op == OP_IDLE ##1 st_ff.op == OP_RUN);
endmodule : iss_seq

// *** iss_host_model.sv ***
`timescale 1ns/1ps
module iss_host_model (
	input wire logic sys_clk_i,
	output logic sync_pin_o
);
	// pin rests low between requests, so a stale level is never taken for a trigger
	initial sync_pin_o = 1'b0;
	// high time is set per request: a short one is a quick host, a long one a slow host
	task automatic pulse(input int hold);
		@(posedge sys_clk_i);
		sync_pin_o <= 1'b1;
		repeat (hold) @(posedge sys_clk_i);
		sync_pin_o <= 1'b0;
	endtask : pulse
endmodule : iss_host_model

// *** iss_seq_tb.sv ***
`timescale 1ns/1ps
module iss_seq_tb import iss_pkg::*;;
	localparam int ROWS_T = 8;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hsel = 1'b0;
	logic [2:0] hsize = 3'h0;
	// per-call bus qualifiers: narrow writes and deselected transfers must be ignored
	logic bus_sel = 1'b1;
	logic [2:0] bus_size = HSIZE_WORD;
	logic hreadyout, hresp, sync_pin, integrating, frame_done, roll_valid, roll_fs;
	logic [31:0] hrdata;
	logic [31:0] rdat;
	logic [2:0] op_state;
	logic [1:0] rd_phase;
	logic [ROW_W-1:0] g_row, roll_read, roll_reset;
	logic [ROW_W-1:0] prev_row = '0;
	int n_errors = 0;
	int cmp_count = 0;
	int frames = 0;
	int rstarts = 0;
	int int_cyc = 0;
	int drops = 0;
	int seq_bad = 0;
	bit overlap = 1'b0;
	bit roll_on = 1'b0;

	always #4 sys_clk = ~sys_clk;

	iss_seq #(.ROWS(ROWS_T), .FOT_CYC(4), .LINE_CYC(2)) iss_seq_i (
		.sys_clk_i(sys_clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .sync_pin_i(sync_pin),
		.op_state_o(op_state), .integrating_o(integrating), .readout_phase_o(rd_phase),
		.global_row_o(g_row), .frame_done_o(frame_done), .roll_read_row_o(roll_read),
		.roll_reset_row_o(roll_reset), .roll_read_valid_o(roll_valid), .roll_frame_start_o(roll_fs)
	);
	iss_host_model iss_host_model_i (.sys_clk_i(sys_clk), .sync_pin_o(sync_pin));

	// values sampled before the edge updates land, so no race with the design flops
	always @(posedge sys_clk) begin
		if (frame_done === 1'b1) frames++;
		if (roll_fs === 1'b1) rstarts++;
		if (integrating === 1'b1) int_cyc++;
		if (integrating === 1'b1 && rd_phase === 2'h2) overlap = 1'b1;
		if (roll_on && roll_valid !== 1'b1) drops++;
		if (roll_on && roll_read !== prev_row && roll_read !== ROW_W'((int'(prev_row) + 1) % ROWS_T)) seq_bad++;
		prev_row = roll_read;
	end

	task automatic wrap_up();
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	function automatic logic [31:0] ba(input logic [IDX_W-1:0] idx);
		return 32'({idx, 2'b00});
	endfunction : ba

	task automatic bus(input logic [31:0] addr, input logic wr_en, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= bus_sel;
		htrans <= 2'h2;
		haddr <= addr;
		hwrite <= wr_en;
		hsize <= bus_size;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		chk("hresp", 32'(hresp), 32'h0);
	endtask : bus

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
		bus(ba(idx), 1'b1, d);
	endtask : wr

	task automatic op_is(input logic [2:0] e);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("op_state", 32'(op_state), 32'(e));
	endtask : op_is

	task automatic dist_is(input int e);
		repeat (6) begin
			@(negedge sys_clk);
			chk("roll_dist", 32'((int'(roll_reset) - int'(roll_read) + ROWS_T) % ROWS_T), 32'(e));
		end
	endtask : dist_is

	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		op_is(3'h1);
		wr(IDX_LVDS, 32'h7);
		bus(ba(IDX_LVDS), 1'b0, 32'h0);
		chk("lvds_stby1", rdat, 32'h0);
		repeat (HRST_WAIT_CYC) @(posedge sys_clk);
		wr(IDX_LOGIC, 32'h1);
		op_is(3'h2);
		bus(ba(IDX_LOGIC), 1'b0, 32'h0);
		chk("logic_en", rdat, 32'h1);
		wr(IDX_SEQ_CFG, 32'h0bc3);
		op_is(3'h3);
		bus_size = 3'h0;
		wr(IDX_INT, 32'h5);
		bus_size = HSIZE_WORD;
		bus_sel = 1'b0;
		wr(IDX_INT, 32'h6);
		bus_sel = 1'b1;
		bus(ba(IDX_INT), 1'b0, 32'h0);
		chk("int_refused", rdat, 32'h0);
		wr(IDX_INT, 32'h1);
		bus(ba(IDX_INT), 1'b0, 32'h0);
		chk("int_stby2", rdat, 32'h1);
		wr(IDX_LVDS, 32'h7);
		bus(ba(IDX_LVDS), 1'b0, 32'h0);
		chk("lvds_stby2", rdat, 32'h7);
		op_is(3'h4);
		wr(IDX_INT, 32'h1);
		wr(IDX_MODE, 32'h8);
		op_is(3'h4);
		wr(IDX_MODE, 32'h9);
		op_is(3'h5);
		bus(ba(IDX_STATUS), 1'b0, 32'h0);
		chk("status_op", {29'h0, rdat[2:0]}, 32'h5);
		frames = 0;
		// pin pulse whose fall lands mid readout and must change nothing
		fork
			iss_host_model_i.pulse(12);
			begin
				@(posedge sys_clk);
				repeat (2) @(posedge sys_clk);
				@(negedge sys_clk);
				chk("int_early", 32'(integrating), 32'h0);
				@(negedge sys_clk);
				chk("int_start", 32'(integrating), 32'h1);
			end
		join
		repeat (60) @(posedge sys_clk);
		chk("frames_one", 32'(frames), 32'h1);
		@(negedge sys_clk);
		chk("phase_idle", 32'(rd_phase), 32'h0);
		iss_host_model_i.pulse(3);
		for (int k = 0; k < 200 && rd_phase !== 2'h2; k++) @(posedge sys_clk);
		iss_host_model_i.pulse(3);
		repeat (80) @(posedge sys_clk);
		chk("overlap", 32'(overlap), 32'h1);
		chk("frames_three", 32'(frames), 32'h3);
		wr(IDX_MODE, 32'hd);
		op_is(3'h5);
		frames = 0;
		int_cyc = 0;
		iss_host_model_i.pulse(20);
		repeat (60) @(posedge sys_clk);
		chk("slave_int", 32'(int_cyc), 32'h14);
		chk("slave_one", 32'(frames), 32'h1);
		iss_host_model_i.pulse(5);
		repeat (60) @(posedge sys_clk);
		chk("slave_two", 32'(frames), 32'h2);
		wr(IDX_INT, 32'h3);
		wr(IDX_MODE, 32'h3);
		for (int k = 0; k < 200 && roll_valid !== 1'b1; k++) @(posedge sys_clk);
		@(posedge sys_clk);
		roll_on = 1'b1;
		rstarts = 0;
		dist_is(3);
		wr(IDX_INT, 32'h2);
		repeat (40) @(posedge sys_clk);
		dist_is(2);
		roll_on = 1'b0;
		chk("roll_drops", 32'(drops), 32'h0);
		chk("roll_seq", 32'(seq_bad), 32'h0);
		chk("roll_frames", 32'(rstarts >= 2), 32'h1);
		wr(IDX_MODE, 32'h2);
		op_is(3'h4);
		wr(IDX_LVDS, 32'h0);
		op_is(3'h3);
		bus(32'h0000_0820, 1'b0, 32'h0);
		chk("unmapped", rdat, 32'h0);
		wrap_up();
	end

	// whole run is under two thousand cycles; this only cuts a hang short
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		wrap_up();
	end
endmodule : iss_seq_tb
